//--- hw/ulsm_defs.vh
`ifndef ULSM_DEFS_VH
`define ULSM_DEFS_VH

// Register offsets on the 3-bit register port.
`define ULSM_A_DATA 3'h0
`define ULSM_A_CTRL 3'h1
`define ULSM_A_MLC 3'h4
`define ULSM_A_LSTAT 3'h5
`define ULSM_A_ISTAT 3'h6
`define ULSM_A_IMASK 3'h7

// Fields of the control register.
`define ULSM_CTRL_FIFO 0
`define ULSM_CTRL_THRIE 1

// Fields of the modem_line_control register.
`define ULSM_MLC_DTR 0
`define ULSM_MLC_RTS 1
`define ULSM_MLC_AUX1 2
`define ULSM_MLC_AUX2 3
`define ULSM_MLC_LOOP 4

// Fields of the line_status register.
`define ULSM_LS_DR 0
`define ULSM_LS_OE 1
`define ULSM_LS_PE 2
`define ULSM_LS_FE 3
`define ULSM_LS_BI 4
`define ULSM_LS_THRE 5
`define ULSM_LS_TEMT 6
`define ULSM_LS_FERR 7

// Fields of the interrupt status and mask registers.
`define ULSM_IRQ_RXDATA 0
`define ULSM_IRQ_LINE 1
`define ULSM_IRQ_THRE 2

// Reset values.
`define ULSM_RST_CTRL 2'h0
`define ULSM_RST_MLC 5'h00
`define ULSM_RST_IRQ 3'h0

// FIFO depth in FIFO mode and in single-holding-register mode.
`define ULSM_DEPTH 5'h10
`define ULSM_DEPTH1 5'h01

`endif

//--- hw/ulsm_top.v
// Summary of operation
// - Interrupt enable 0: pin tristated, loop carrier 1.
// - Interrupt enable 1: pin driven, loop carrier 0.
// - First aux bit drives looped ring only.
// - Request-to-send pin is inverted control bit.
// - Terminal-ready pin is inverted control bit.
// - FIFO error bit while errored chars; read clears.
// - Transmitter empty when holding and shifter empty.
// - Holding empty on shift load; write clears.
// - FIFO mode: empty FIFO sets, write clears.
// - Holding empty with enable raises interrupt.
// - Break flagged; one break char per break in FIFO mode.
// - Framing error reported with head character.
// - Parity error reported with head character.
// - Overrun when full; character dropped, FIFO intact.
// - Data ready while a character waits.
// - Loop-back disconnects pins, routes outputs internally.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`include "ulsm_defs.vh"

module ulsm_top (
	input wire CLOCK,
	input wire RST_B,
	input wire [2:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [7:0] RDATA,
	output wire IRQ,
	input wire RX_CHAR_VALID,
	input wire [7:0] RX_CHAR,
	input wire RX_PAR_ERR,
	input wire RX_FRM_ERR,
	input wire RX_BREAK,
	output wire TX_VALID,
	output wire [7:0] TX_DATA,
	input wire TX_LOAD,
	input wire TX_SHIFT_EMPTY,
	input wire TXD_ENGINE,
	output reg RXD_ENGINE,
	output reg TXD,
	input wire RXD,
	output reg RTS_B,
	output reg DTR_B,
	input wire CTS_B_PIN,
	input wire DSR_B_PIN,
	input wire DCD_B_PIN,
	input wire RI_B_PIN,
	output reg CTS_B_INT,
	output reg DSR_B_INT,
	output reg DCD_B_INT,
	output reg RI_B_INT,
	output reg INT_O,
	output reg INT_OE_B
);

	reg [1:0] ctrl_r;
	reg [4:0] mlc_r;
	reg [2:0] imask_r;
	reg [2:0] istat_r;
	reg [2:0] istat_nxt;
	reg [7:0] rx_dat_r [0:15];
	reg [2:0] rx_flg_r [0:15];
	reg [7:0] tx_dat_r [0:15];
	reg [3:0] rx_wp_r;
	reg [3:0] rx_rp_r;
	reg [4:0] rx_cnt_r;
	reg [3:0] tx_wp_r;
	reg [3:0] tx_rp_r;
	reg [4:0] tx_cnt_r;
	reg [4:0] err_cnt_r;
	reg err_ack_r;
	reg head_ack_r;
	reg ovr_r;
	reg brk_seen_r;
	reg thre_d_r;
	reg [7:0] lstat;

	wire fifo_en = ctrl_r[`ULSM_CTRL_FIFO];
	wire thr_ie = ctrl_r[`ULSM_CTRL_THRIE];
	wire loop = mlc_r[`ULSM_MLC_LOOP];
	wire [4:0] depth = fifo_en ? `ULSM_DEPTH : `ULSM_DEPTH1;
	wire rx_full = (rx_cnt_r == depth);
	wire rx_empty = (rx_cnt_r == 5'h00);
	wire tx_full = (tx_cnt_r == depth);
	wire tx_empty = (tx_cnt_r == 5'h00);
	wire [2:0] rx_in_flg = {RX_BREAK, RX_FRM_ERR, RX_PAR_ERR};
	wire rx_in_err = |rx_in_flg;
	wire [2:0] head_flg = rx_flg_r[rx_rp_r];

	// A break keeps arriving as zero characters; in FIFO mode only the first one is stored.
	wire brk_drop = fifo_en & RX_BREAK & brk_seen_r;
	wire rx_take = RX_CHAR_VALID & ~brk_drop;
	wire rx_push = rx_take & ~rx_full;
	wire rx_ovr = rx_take & rx_full;
	wire rd_data = RD & (ADDR == `ULSM_A_DATA);
	wire rd_lstat = RD & (ADDR == `ULSM_A_LSTAT);
	wire rx_pop = rd_data & ~rx_empty;
	wire tx_push = WR & (ADDR == `ULSM_A_DATA) & ~tx_full;
	wire tx_pop = TX_LOAD & ~tx_empty;
	wire ctrl_wr = WR & (ADDR == `ULSM_A_CTRL);
	wire fifo_flush = ctrl_wr & (WDATA[`ULSM_CTRL_FIFO] != fifo_en);

	// Holding empty is simply an empty queue: one deep outside FIFO mode.
	wire thre = tx_empty;
	wire temt = tx_empty & TX_SHIFT_EMPTY;

	// Per-entry storage of both queues; writes go to the entry under the pointer.
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_entry
			always @(posedge CLOCK) begin
				if (rx_push && rx_wp_r == gi) begin
					rx_dat_r[gi] <= RX_CHAR;
					rx_flg_r[gi] <= rx_in_flg;
				end
				if (tx_push && tx_wp_r == gi) begin
					tx_dat_r[gi] <= WDATA;
				end
			end
		end
	endgenerate

	assign TX_VALID = ~tx_empty;
	assign TX_DATA = tx_dat_r[tx_rp_r];

	// Receive queue pointers and count; a mode change empties both queues.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rx_wp_r <= 4'h0;
			rx_rp_r <= 4'h0;
			rx_cnt_r <= 5'h00;
		end else if (fifo_flush) begin
			rx_wp_r <= 4'h0;
			rx_rp_r <= 4'h0;
			rx_cnt_r <= 5'h00;
		end else begin
			if (rx_push) begin
				rx_wp_r <= fifo_en ? rx_wp_r + 4'h1 : 4'h0;
			end
			if (rx_pop) begin
				rx_rp_r <= fifo_en ? rx_rp_r + 4'h1 : 4'h0;
			end
			rx_cnt_r <= rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop};
		end
	end

	// Transmit queue pointers and count; full writes are dropped silently.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			tx_wp_r <= 4'h0;
			tx_rp_r <= 4'h0;
			tx_cnt_r <= 5'h00;
		end else if (fifo_flush) begin
			tx_wp_r <= 4'h0;
			tx_rp_r <= 4'h0;
			tx_cnt_r <= 5'h00;
		end else begin
			if (tx_push) begin
				tx_wp_r <= fifo_en ? tx_wp_r + 4'h1 : 4'h0;
			end
			if (tx_pop) begin
				tx_rp_r <= fifo_en ? tx_rp_r + 4'h1 : 4'h0;
			end
			tx_cnt_r <= tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop};
		end
	end

	// Break tracking: armed by a stored break, released by any normal character.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			brk_seen_r <= 1'b0;
		end else if (RX_CHAR_VALID) begin
			brk_seen_r <= RX_BREAK & (brk_seen_r | rx_push);
		end
	end

	// Errored entries are counted so the summary bit never scans the array.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			err_cnt_r <= 5'h00;
		end else if (fifo_flush) begin
			err_cnt_r <= 5'h00;
		end else begin
			err_cnt_r <= err_cnt_r + {4'h0, rx_push & rx_in_err}
				- {4'h0, rx_pop & (|head_flg)};
		end
	end

	// Acknowledge flags for status reads; a new event in the same cycle wins.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			err_ack_r <= 1'b0;
			head_ack_r <= 1'b0;
			ovr_r <= 1'b0;
		end else begin
			if (rx_push & rx_in_err) begin
				err_ack_r <= 1'b0;
			end else if (rd_lstat) begin
				err_ack_r <= 1'b1;
			end
			if (rx_pop | (rx_push & rx_empty) | fifo_flush) begin
				head_ack_r <= 1'b0;
			end else if (rd_lstat) begin
				head_ack_r <= 1'b1;
			end
			if (rx_ovr) begin
				ovr_r <= 1'b1;
			end else if (rd_lstat) begin
				ovr_r <= 1'b0;
			end
		end
	end

	// Line status is assembled from live queue state and the sticky flags.
	always @* begin
		lstat = 8'h00;
		lstat[`ULSM_LS_DR] = ~rx_empty;
		lstat[`ULSM_LS_OE] = ovr_r;
		lstat[`ULSM_LS_PE] = ~rx_empty & head_flg[0] & ~head_ack_r;
		lstat[`ULSM_LS_FE] = ~rx_empty & head_flg[1] & ~head_ack_r;
		lstat[`ULSM_LS_BI] = ~rx_empty & head_flg[2] & ~head_ack_r;
		lstat[`ULSM_LS_THRE] = thre;
		lstat[`ULSM_LS_TEMT] = temt;
		lstat[`ULSM_LS_FERR] = fifo_en & (err_cnt_r != 5'h00) & ~err_ack_r;
	end

	// Software-written configuration.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_r <= `ULSM_RST_CTRL;
			mlc_r <= `ULSM_RST_MLC;
			imask_r <= `ULSM_RST_IRQ;
		end else if (WR) begin
			case (ADDR)
				`ULSM_A_CTRL: begin
					ctrl_r <= WDATA[1:0];
				end
				`ULSM_A_MLC: begin
					mlc_r <= WDATA[4:0];
				end
				`ULSM_A_IMASK: begin
					imask_r <= WDATA[2:0];
				end
				default: begin
					ctrl_r <= ctrl_r;
				end
			endcase
		end
	end

	// Sticky event bits, write one to clear; an event in the clear cycle survives.
	always @* begin
		istat_nxt = istat_r;
		if (WR && ADDR == `ULSM_A_ISTAT) begin
			istat_nxt = istat_r & ~WDATA[2:0];
		end
		if (rx_push) begin
			istat_nxt[`ULSM_IRQ_RXDATA] = 1'b1;
		end
		if (rx_ovr | (rx_push & rx_in_err)) begin
			istat_nxt[`ULSM_IRQ_LINE] = 1'b1;
		end
		if (thre & ~thre_d_r) begin
			istat_nxt[`ULSM_IRQ_THRE] = 1'b1;
		end
	end

	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			istat_r <= `ULSM_RST_IRQ;
			thre_d_r <= 1'b1;
		end else begin
			istat_r <= istat_nxt;
			thre_d_r <= thre;
		end
	end

	// Level request to the CPU; the holding-empty term stays up while enabled.
	assign IRQ = (|(istat_r & imask_r)) | (thre & thr_ie);

	// Read data for the cycle after the strobe; unmapped offsets read zero.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			case (ADDR)
				`ULSM_A_DATA: begin
					RDATA <= rx_empty ? 8'h00 : rx_dat_r[rx_rp_r];
				end
				`ULSM_A_CTRL: begin
					RDATA <= {6'h00, ctrl_r};
				end
				`ULSM_A_MLC: begin
					RDATA <= {3'h0, mlc_r};
				end
				`ULSM_A_LSTAT: begin
					RDATA <= lstat;
				end
				`ULSM_A_ISTAT: begin
					RDATA <= {5'h00, istat_r};
				end
				`ULSM_A_IMASK: begin
					RDATA <= {5'h00, imask_r};
				end
				default: begin
					RDATA <= 8'h00;
				end
			endcase
		end
	end

	// Pin and loop-back routing, all registered so the pins never glitch.
	// In loop-back the line pins idle inactive and inputs are ignored.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			TXD <= 1'b1;
			RXD_ENGINE <= 1'b1;
			RTS_B <= 1'b1;
			DTR_B <= 1'b1;
			CTS_B_INT <= 1'b1;
			DSR_B_INT <= 1'b1;
			DCD_B_INT <= 1'b1;
			RI_B_INT <= 1'b1;
			INT_O <= 1'b0;
			INT_OE_B <= 1'b1;
		end else begin
			TXD <= loop ? 1'b1 : TXD_ENGINE;
			RXD_ENGINE <= loop ? TXD_ENGINE : RXD;
			RTS_B <= loop ? 1'b1 : ~mlc_r[`ULSM_MLC_RTS];
			DTR_B <= loop ? 1'b1 : ~mlc_r[`ULSM_MLC_DTR];
			CTS_B_INT <= loop ? ~mlc_r[`ULSM_MLC_RTS] : CTS_B_PIN;
			DSR_B_INT <= loop ? ~mlc_r[`ULSM_MLC_DTR] : DSR_B_PIN;
			DCD_B_INT <= loop ? ~mlc_r[`ULSM_MLC_AUX2] : DCD_B_PIN;
			RI_B_INT <= loop ? ~mlc_r[`ULSM_MLC_AUX1] : RI_B_PIN;
			INT_O <= IRQ;
			INT_OE_B <= ~mlc_r[`ULSM_MLC_AUX2];
		end
	end

endmodule // ulsm_top

//--- testbench/ulsm_asserts.sv
`timescale 1ns/1ps
// Judges the pins against shadow copies of the control registers.
module ulsm_asserts (
	input wire CLOCK,
	input wire RST_B,
	input wire [2:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR,
	input wire IRQ,
	input wire TX_VALID,
	input wire TXD_ENGINE,
	input wire TXD,
	input wire RXD,
	input wire RXD_ENGINE,
	input wire RTS_B,
	input wire DTR_B,
	input wire CTS_B_PIN,
	input wire DCD_B_PIN,
	input wire RI_B_PIN,
	input wire CTS_B_INT,
	input wire DCD_B_INT,
	input wire RI_B_INT,
	input wire INT_O,
	input wire INT_OE_B
);
	reg [4:0] mlc_r;
	reg ie_r;
	// The shadows see the same writes, so nothing inside the design is peeked at.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			mlc_r <= 5'h00;
			ie_r <= 1'b0;
		end else if (WR && ADDR == 3'h4) begin
			mlc_r <= WDATA[4:0];
		end else if (WR && ADDR == 3'h1) begin
			ie_r <= WDATA[1];
		end
	end
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RST_B);
	a_rts_pin: assert property (RTS_B == ($past(mlc_r[4]) | !$past(mlc_r[1])))
		else $error("rts pin wrong");
	a_dtr_pin: assert property (DTR_B == ($past(mlc_r[4]) | !$past(mlc_r[0])))
		else $error("dtr pin wrong");
	a_int_enable: assert property (INT_OE_B == !$past(mlc_r[3]))
		else $error("int enable wrong");
	a_loop_dcd: assert property (DCD_B_INT ==
		($past(mlc_r[4]) ? !$past(mlc_r[3]) : $past(DCD_B_PIN))) else $error("dcd wrong");
	a_loop_ri: assert property (RI_B_INT ==
		($past(mlc_r[4]) ? !$past(mlc_r[2]) : $past(RI_B_PIN))) else $error("ri wrong");
	a_txd_pin: assert property (TXD == ($past(mlc_r[4]) | $past(TXD_ENGINE)))
		else $error("txd wrong");
	a_thr_irq: assert property (ie_r && !TX_VALID |-> IRQ)
		else $error("irq missing");
	a_tx_push: assert property (WR && ADDR == 3'h0 && !TX_VALID |=> TX_VALID)
		else $error("push lost");
	a_rxd_route: assert property (RXD_ENGINE ==
		($past(mlc_r[4]) ? $past(TXD_ENGINE) : $past(RXD))) else $error("rxd route wrong");
	a_loop_cts: assert property (CTS_B_INT ==
		($past(mlc_r[4]) ? !$past(mlc_r[1]) : $past(CTS_B_PIN))) else $error("cts wrong");
	a_int_follow: assert property (INT_O == $past(IRQ))
		else $error("int pin wrong");
endmodule // ulsm_asserts

//--- testbench/ulsm_engine_model.sv
`timescale 1ns/1ps
// Serial engine and modem stand-in; STALL holds the next character back.
module ulsm_engine_model (
	input wire CLOCK,
	input wire RST_B,
	input wire STALL,
	input wire TX_VALID,
	output reg TX_LOAD,
	output wire TX_SHIFT_EMPTY,
	output wire TXD_ENGINE,
	output wire RXD,
	output wire CTS_B_PIN,
	output wire DSR_B_PIN,
	output wire DCD_B_PIN,
	output wire RI_B_PIN
);
	reg [2:0] bits_r;
	// The line wiggles while shifting, so a stuck route shows.
	assign TX_SHIFT_EMPTY = (bits_r == 3'h0);
	assign TXD_ENGINE = ~bits_r[0];
	// The far end echoes the line inverted, so a looped route and a pin route differ.
	// It rests high in reset like the modem lines.
	assign RXD = RST_B ? ~TXD_ENGINE : 1'b1;
	// Modem lines rest high in reset, then show a mixed pattern.
	assign {CTS_B_PIN, DSR_B_PIN, DCD_B_PIN, RI_B_PIN} = RST_B ? 4'h5 : 4'hF;
	// Pops only while the shifter is free, as a real engine would.
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			TX_LOAD <= 1'b0;
			bits_r <= 3'h0;
		end else begin
			TX_LOAD <= TX_VALID && !STALL && bits_r == 3'h0 && !TX_LOAD;
			if (TX_LOAD)
				bits_r <= 3'h5;
			else if (bits_r != 3'h0)
				bits_r <= bits_r - 3'h1;
		end
	end
endmodule // ulsm_engine_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg CLOCK = 1'b0;
	reg RST_B = 1'b0;
	reg STALL = 1'b1;
	reg WR = 1'b0, RD = 1'b0, RX_CHAR_VALID = 1'b0;
	reg RX_PAR_ERR = 1'b0, RX_FRM_ERR = 1'b0, RX_BREAK = 1'b0;
	reg [2:0] ADDR = 3'h0;
	reg [7:0] WDATA = 8'h00, RX_CHAR = 8'h00;
	wire [7:0] RDATA, TX_DATA;
	wire IRQ, TX_VALID, TX_LOAD, TX_SHIFT_EMPTY, TXD_ENGINE, RXD_ENGINE, TXD, RXD, INT_O;
	wire RTS_B, DTR_B, INT_OE_B, CTS_B_PIN, DSR_B_PIN, DCD_B_PIN, RI_B_PIN;
	wire CTS_B_INT, DSR_B_INT, DCD_B_INT, RI_B_INT;
	wire [7:0] pins = {RTS_B, DTR_B, INT_OE_B, TXD, CTS_B_INT, DSR_B_INT, DCD_B_INT, RI_B_INT};
	// Each row is a modem_line_control value, then the pins it should give.
	wire [127:0] rows = 128'h13F3_18DD_14FE_10FF_0CD5_0275_01B5_00F5;
	integer n_fail = 0, total_checks = 0, i, k;
	ulsm_top ulsm_top_inst (
		.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .IRQ(IRQ), .RX_CHAR_VALID(RX_CHAR_VALID), .RX_CHAR(RX_CHAR),
		.RX_PAR_ERR(RX_PAR_ERR), .RX_FRM_ERR(RX_FRM_ERR), .RX_BREAK(RX_BREAK),
		.TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LOAD(TX_LOAD),
		.TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .TXD_ENGINE(TXD_ENGINE), .RXD_ENGINE(RXD_ENGINE),
		.TXD(TXD), .RXD(RXD), .RTS_B(RTS_B), .DTR_B(DTR_B), .CTS_B_PIN(CTS_B_PIN),
		.DSR_B_PIN(DSR_B_PIN), .DCD_B_PIN(DCD_B_PIN), .RI_B_PIN(RI_B_PIN),
		.CTS_B_INT(CTS_B_INT), .DSR_B_INT(DSR_B_INT), .DCD_B_INT(DCD_B_INT),
		.RI_B_INT(RI_B_INT), .INT_O(INT_O), .INT_OE_B(INT_OE_B)
	);
	ulsm_engine_model ulsm_engine_model_inst (
		.CLOCK(CLOCK), .RST_B(RST_B), .STALL(STALL), .TX_VALID(TX_VALID), .TX_LOAD(TX_LOAD),
		.TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .TXD_ENGINE(TXD_ENGINE), .RXD(RXD),
		.CTS_B_PIN(CTS_B_PIN), .DSR_B_PIN(DSR_B_PIN), .DCD_B_PIN(DCD_B_PIN),
		.RI_B_PIN(RI_B_PIN)
	);
	// A 25 MHz clock.
	always #20 CLOCK = ~CLOCK;
	// Compares one 8-bit result.
	task chk(input [39:0] nm, input [7:0] e, input [7:0] g);
		total_checks = total_checks + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("[ERR] %0s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input [2:0] a, input [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask
	// Read data appear in the cycle after the strobe and hold until the next read, so look there.
	task rd(input [2:0] a, input [7:0] e);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		@(negedge CLOCK);
		chk("rdata", e, RDATA);
	endtask
	task rx(input [2:0] f, input [7:0] c);
		@(posedge CLOCK);
		RX_CHAR_VALID <= 1'b1;
		RX_CHAR <= c;
		{RX_BREAK, RX_FRM_ERR, RX_PAR_ERR} <= f;
		@(posedge CLOCK);
		RX_CHAR_VALID <= 1'b0;
	endtask
	task finish_test;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Main sequence: pin table, then transmit, receive and interrupt cases.
	initial begin
		repeat (20) @(posedge CLOCK);
		RST_B <= 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			wr(3'h4, rows[i*16+8 +: 8]);
			repeat (2) @(negedge CLOCK);
			chk("pins", rows[i*16 +: 8], pins);
			rd(3'h4, rows[i*16+8 +: 8]);
		end
		wr(3'h4, 8'h00);
		wr(3'h3, 8'hFF);
		rd(3'h3, 8'h00);
		for (i = 0; i < 2; i = i + 1) begin
			wr(3'h1, 8'h02 | i[7:0]);
			wr(3'h0, 8'hA5);
			wr(3'h0, 8'h5A);
			rd(3'h5, 8'h00);
			chk("txdat", 8'hA5, TX_DATA);
			chk("irq", 8'h00, {7'h0, IRQ});
			STALL <= 1'b0;
			for (k = 0; k < 99 && !(TX_SHIFT_EMPTY && !TX_VALID); k = k + 1)
				@(negedge CLOCK);
			rd(3'h5, 8'h60);
			chk("irq", 8'h01, {7'h0, IRQ});
			STALL <= 1'b1;
		end
		rx(3'h1, 8'h3C);
		rd(3'h5, 8'hE5);
		rd(3'h5, 8'h61);
		rd(3'h0, 8'h3C);
		rd(3'h5, 8'h60);
		for (k = 0; k < 3; k = k + 1)
			rx(3'h4, 8'h00);
		rd(3'h5, 8'hF1);
		rd(3'h0, 8'h00);
		rd(3'h5, 8'h60);
		wr(3'h1, 8'h00);
		rx(3'h2, 8'h81);
		rd(3'h5, 8'h69);
		rd(3'h0, 8'h81);
		rx(3'h0, 8'h11);
		rx(3'h0, 8'h22);
		rd(3'h5, 8'h63);
		rd(3'h0, 8'h11);
		rd(3'h5, 8'h60);
		// Old events are cleared first, so only the new character can raise the line.
		wr(3'h6, 8'h07);
		wr(3'h7, 8'h01);
		@(negedge CLOCK);
		chk("irq", 8'h00, {7'h0, IRQ});
		rx(3'h0, 8'h77);
		@(negedge CLOCK);
		chk("irq", 8'h01, {7'h0, IRQ});
		wr(3'h6, 8'h07);
		rd(3'h6, 8'h00);
		chk("irq", 8'h00, {7'h0, IRQ});
		wr(3'h7, 8'h00);
		rd(3'h0, 8'h77);
		rx(3'h0, 8'h78);
		rd(3'h6, 8'h01);
		chk("irq", 8'h00, {7'h0, IRQ});
		// A clear and a new character in one cycle: the event must survive.
		rd(3'h0, 8'h78);
		wr(3'h6, 8'h07);
		@(posedge CLOCK);
		ADDR <= 3'h6;
		WDATA <= 8'h01;
		WR <= 1'b1;
		RX_CHAR_VALID <= 1'b1;
		RX_CHAR <= 8'h79;
		@(posedge CLOCK);
		WR <= 1'b0;
		RX_CHAR_VALID <= 1'b0;
		rd(3'h6, 8'h01);
		rd(3'h0, 8'h79);
		// A reset in mid-run must put the pins, read data, interrupt, modem_line_control and line status back at rest.
		wr(3'h4, 8'h0F);
		@(posedge CLOCK);
		RST_B <= 1'b0;
		repeat (2) @(negedge CLOCK);
		chk("rpins", 8'hFF, pins);
		chk("rdata", 8'h00, RDATA);
		chk("irq", 8'h00, {7'h0, IRQ});
		@(posedge CLOCK);
		RST_B <= 1'b1;
		rd(3'h4, 8'h00);
		rd(3'h5, 8'h60);
		finish_test;
	end
	// Cuts a hang short; the sequence needs well under a tenth of this span.
	initial begin
		#400000;
		n_fail = n_fail + 1;
		finish_test;
	end
endmodule // tb_top
bind ulsm_top ulsm_asserts ulsm_asserts_inst (
	.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .IRQ(IRQ),
	.TX_VALID(TX_VALID), .TXD_ENGINE(TXD_ENGINE), .TXD(TXD), .RXD(RXD),
	.RXD_ENGINE(RXD_ENGINE), .RTS_B(RTS_B), .DTR_B(DTR_B), .CTS_B_PIN(CTS_B_PIN),
	.DCD_B_PIN(DCD_B_PIN), .RI_B_PIN(RI_B_PIN), .CTS_B_INT(CTS_B_INT),
	.DCD_B_INT(DCD_B_INT), .RI_B_INT(RI_B_INT), .INT_O(INT_O), .INT_OE_B(INT_OE_B)
);
